// ### rtl/mdio_regs.v
// Small management register bank addressed by the current address
`timescale 1ns/100ps
`include "xgmii_mdio_map.vh"
module mdio_regs #(
  parameter DEPTH_LOG = 4
) (
  // Clock and reset
  input  wire        clock,
  input  wire        sys_rst,
  // Access
  input  wire        wr_en,
  input  wire [15:0] addr,
  input  wire [15:0] wr_data,
  input  wire [1:0]  map_sel,
  output reg  [15:0] rd_data
);
  reg [15:0] mem_q [0:(1<<DEPTH_LOG)-1];
  integer    i;

  // Writes land in the low address window; reads beyond it give zero
  always @(posedge clock) begin
    if (sys_rst) begin
      for (i = 0; i < (1<<DEPTH_LOG); i = i + 1)
        mem_q[i] <= `REG_RESET;
    end else if (wr_en && addr[15:DEPTH_LOG] == 0) begin
      mem_q[addr[DEPTH_LOG-1:0]] <= wr_data;
    end
  end

  // Read path; last word reports the selected map in its low bits
  always @* begin
    if (addr[15:DEPTH_LOG] != 0)
      rd_data = 16'h0000;
    else if (addr[DEPTH_LOG-1:0] == {DEPTH_LOG{1'b1}})
      rd_data = {14'h0000, map_sel};
    else
      rd_data = mem_q[addr[DEPTH_LOG-1:0]];
  end
endmodule // mdio_regs

// ### rtl/pair_buffer.v
// Two-entry valid/ready buffer for one 72-bit client word
`timescale 1ns/100ps
module pair_buffer #(
  parameter WIDTH = 72
) (
  // Clock and reset
  input  wire             clock,
  input  wire             sys_rst,
  // Filling side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] slot_q [0:1];
  reg             rd_q;
  reg             wr_q;
  reg [1:0]       count_q;
  wire            push;
  wire            pop;

  // Handshake terms
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign in_ready  = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data  = slot_q[rd_q];

  // Storage and pointers
  always @(posedge clock) begin
    if (sys_rst) begin
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        slot_q[wr_q] <= in_data;
        wr_q         <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      if (push & ~pop)
        count_q <= count_q + 2'h1;
      else if (pop & ~push)
        count_q <= count_q - 2'h1;
    end
  end
endmodule // pair_buffer

// ### rtl/xgmii_mdio_core.v
// 64-bit client path with error marking, and the management slave
`timescale 1ns/100ps
`include "xgmii_mdio_map.vh"
module xgmii_mdio_core #(
  parameter DEPTH_LOG = 4
) (
  // Clock and reset
  input  wire        clock,
  input  wire        sys_rst,
  // Line side receive words from the decoder
  input  wire        line_valid,
  output wire        line_ready,
  input  wire [63:0] line_rxd,
  input  wire [7:0]  line_rxc,
  input  wire [7:0]  line_err,
  // Client receive bus
  output wire [63:0] xgmii_rxd,
  output wire [7:0]  xgmii_rxc,
  output wire        xgmii_rx_valid,
  input  wire        xgmii_rx_ready,
  // Client transmit bus and line side transmit words
  input  wire [63:0] xgmii_txd,
  input  wire [7:0]  xgmii_txc,
  output reg  [63:0] line_txd,
  output reg  [7:0]  line_txc,
  output reg         tx_bad_start,
  // Management pins
  input  wire        mdc,
  input  wire        mdio_in,
  output reg         mdio_out,
  output reg         mdio_oe,
  input  wire [4:0]  prtad,
  input  wire [1:0]  type_sel,
  output reg  [1:0]  map_select
);
  // ------------------------------------------------------------
  // Character helpers
  // ------------------------------------------------------------
  function is_ctl;
    input       c;
    input [7:0] d;
    input [7:0] code;
    begin
      is_ctl = c && (d == code);
    end
  endfunction

  // ------------------------------------------------------------
  // Receive path: error marking, then two-entry buffer
  // ------------------------------------------------------------
  reg  [63:0] rx_mark_d;
  reg  [7:0]  rxc_mark_d;
  reg         rx_in_frame_q;
  integer     n;

  // Mark errored lanes, keep Start only in lane 0 or 4
  always @* begin
    rx_mark_d  = line_rxd;
    rxc_mark_d = line_rxc;
    for (n = 0; n < `LANE_COUNT; n = n + 1) begin
      if (line_err[n]) begin
        rx_mark_d[8*n +: 8] = `CHAR_ERROR;
        rxc_mark_d[n]       = 1'b1;
      end else if (n != 0 && n != 4 &&
                   is_ctl(line_rxc[n], line_rxd[8*n +: 8], `CHAR_START)) begin
        rx_mark_d[8*n +: 8] = `CHAR_ERROR;
      end
    end
  end

  // Frame tracking for the receive bus, lane 4 checked before lane 0
  always @(posedge clock) begin
    if (sys_rst)
      rx_in_frame_q <= 1'b0;
    else if (line_valid && line_ready) begin
      if (is_ctl(rxc_mark_d[4], rx_mark_d[39:32], `CHAR_START))
        rx_in_frame_q <= 1'b1;
      else if (|(line_rxc & ~line_err) && !is_ctl(rxc_mark_d[0], rx_mark_d[7:0],
               `CHAR_START))
        rx_in_frame_q <= 1'b0;
      else if (is_ctl(rxc_mark_d[0], rx_mark_d[7:0], `CHAR_START))
        rx_in_frame_q <= 1'b1;
    end
  end

  // Buffer carries data and control side by side, one word per edge
  pair_buffer #(.WIDTH(72)) rx_buf (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (line_valid),
    .in_ready  (line_ready),
    .in_data   ({rxc_mark_d, rx_mark_d}),
    .out_valid (xgmii_rx_valid),
    .out_ready (xgmii_rx_ready),
    .out_data  ({xgmii_rxc, xgmii_rxd})
  );

  // ------------------------------------------------------------
  // Transmit path: register, flag misplaced Start, pass errors
  // ------------------------------------------------------------
  reg bad_start_d;
  integer m;

  // Start outside lanes 0 and 4 is flagged; Error characters pass
  always @* begin
    bad_start_d = 1'b0;
    for (m = 0; m < `LANE_COUNT; m = m + 1)
      if (m != 0 && m != 4 && is_ctl(xgmii_txc[m], xgmii_txd[8*m +: 8], `CHAR_START))
        bad_start_d = 1'b1;
  end

  // Words leave unchanged so Terminate, Idle and Error keep their meaning
  always @(posedge clock) begin
    if (sys_rst) begin
      line_txd     <= {8{`CHAR_IDLE}};
      line_txc     <= 8'hFF;
      tx_bad_start <= 1'b0;
    end else begin
      line_txd     <= xgmii_txd;
      line_txc     <= xgmii_txc;
      tx_bad_start <= bad_start_d;
    end
  end

  // ------------------------------------------------------------
  // Management slave
  // ------------------------------------------------------------
  localparam ST_PRE  = 3'h0;
  localparam ST_HEAD = 3'h1;
  localparam ST_TA   = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_READ = 3'h4;

  reg  [2:0]  state_q;
  reg  [5:0]  ones_q;
  reg  [4:0]  bit_q;
  reg  [13:0] head_q;
  reg  [15:0] shift_q;
  reg  [15:0] cur_addr_q;
  reg         mdc_q;
  reg         match_q;
  reg         wr_en_q;
  wire        mdc_rise;
  wire [15:0] reg_rd;
  wire [1:0]  op;

  assign mdc_rise = mdc & ~mdc_q;
  assign op       = head_q[12:11];

  // Map select caught only while reset is asserted
  always @(posedge clock) begin
    if (sys_rst)
      map_select <= (type_sel == 2'h1) ? `MAP_PCS_PMA : type_sel;
  end

  mdio_regs #(.DEPTH_LOG(DEPTH_LOG)) regs (
    .clock   (clock),
    .sys_rst (sys_rst),
    .wr_en   (wr_en_q),
    .addr    (cur_addr_q),
    .wr_data (shift_q),
    .map_sel (map_select),
    .rd_data (reg_rd)
  );

  // Frame receiver sampled on rising management clock; never initiates
  always @(posedge clock) begin
    if (sys_rst) begin
      state_q    <= ST_PRE;
      ones_q     <= 6'h00;
      bit_q      <= 5'h00;
      head_q     <= 14'h0000;
      shift_q    <= 16'h0000;
      cur_addr_q <= `ADDR_RESET;
      mdc_q      <= 1'b0;
      match_q    <= 1'b0;
      wr_en_q    <= 1'b0;
      mdio_out   <= 1'b1;
      mdio_oe    <= 1'b0;
    end else begin
      mdc_q   <= mdc;
      wr_en_q <= 1'b0;
      if (mdc_rise) begin
        case (state_q)
          ST_PRE: begin
            mdio_oe <= 1'b0;
            if (mdio_in)
              ones_q <= (ones_q == `PRE_ONES) ? ones_q : ones_q + 6'h01;
            else begin
              ones_q <= 6'h00;
              if (ones_q == `PRE_ONES) begin
                state_q <= ST_HEAD;
                bit_q   <= 5'h0D;
                head_q  <= 14'h0000;
              end
            end
          end
          ST_HEAD: begin
            head_q <= {head_q[12:0], mdio_in};
            if (bit_q == 5'h00) begin
              state_q <= ST_TA;
              match_q <= (head_q[9:5] == prtad);
              if (head_q[12] != 1'b1)
                state_q <= ST_PRE;
              else if (head_q[9:5] == prtad && head_q[11]) begin
                // Second turnaround bit is driven low by the slave
                mdio_oe  <= 1'b1;
                mdio_out <= 1'b0;
              end
            end else
              bit_q <= bit_q - 5'h01;
          end
          ST_TA: begin
            bit_q <= `DATA_BITS - 5'h01;
            if (match_q && op[1]) begin
              state_q  <= ST_READ;
              mdio_out <= reg_rd[15];
              shift_q  <= {reg_rd[14:0], 1'b0};
            end else
              state_q <= ST_DATA;
          end
          ST_DATA: begin
            shift_q <= {shift_q[14:0], mdio_in};
            if (bit_q == 5'h00) begin
              state_q <= ST_PRE;
              if (match_q && op == `OP_ADDRESS)
                cur_addr_q <= {shift_q[14:0], mdio_in};
              if (match_q && op == `OP_WRITE)
                wr_en_q <= 1'b1;
            end else
              bit_q <= bit_q - 5'h01;
          end
          ST_READ: begin
            // Release the line on the rise that samples the last bit
            if (bit_q == 5'h00) begin
              state_q  <= ST_PRE;
              mdio_oe  <= 1'b0;
              mdio_out <= 1'b1;
              if (op == `OP_READ_INC)
                cur_addr_q <= cur_addr_q + 16'h0001;
            end else begin
              mdio_out <= shift_q[15];
              shift_q  <= {shift_q[14:0], 1'b0};
              bit_q    <= bit_q - 5'h01;
            end
          end
          default: state_q <= ST_PRE;
        endcase
      end
    end
  end
endmodule // xgmii_mdio_core

// ### rtl/xgmii_mdio_map.vh
// Constants for the 64-bit client path and the management slave
`ifndef XGMII_MDIO_MAP_VH
`define XGMII_MDIO_MAP_VH
// --------------------------------------------------------------
// Client control characters
// --------------------------------------------------------------
`define CHAR_IDLE      8'h07
`define CHAR_START     8'hFB
`define CHAR_TERM      8'hFD
`define CHAR_ERROR     8'hFE
`define LANE_COUNT     8
// --------------------------------------------------------------
// Management frame fields
// --------------------------------------------------------------
`define OP_ADDRESS     2'h0
`define OP_WRITE       2'h1
`define OP_READ_INC    2'h2
`define OP_READ        2'h3
`define PRE_ONES       6'h20
`define DATA_BITS      5'h10
// --------------------------------------------------------------
// Register map selections and reset values
// --------------------------------------------------------------
`define MAP_PCS_PMA    2'h0
`define MAP_DTE_XGXS   2'h2
`define MAP_PHY_XGXS   2'h3
`define ADDR_RESET     16'h0000
`define REG_RESET      16'h0000
`endif

// ### tb/mdio_station.sv
// Station management master driving frames onto the management pins
`timescale 1ns/100ps
module mdio_station (
  // Clock
  input  logic clock,
  // Line level seen by the station
  input  logic line,
  // Management clock and data drive
  output logic mdc,
  output logic drv,
  output logic en
);
  // Clock stands still and data is released between frames
  initial begin
    mdc = 1'b0;
    drv = 1'b1;
    en  = 1'b0;
  end
  // One bit: set while low, line sampled before the rise
  task automatic cyc(input logic b, output logic s);
    @(negedge clock);
    mdc = 1'b0;
    drv = b;
    @(negedge clock);
    s = line;
    @(negedge clock);
    mdc = 1'b1;
    @(negedge clock);
  endtask
  // Whole frame; reads release the line from turnaround on
  task automatic frame(input logic [1:0] op, input logic [4:0] prt, input logic [15:0] d,
                       output logic [15:0] rd);
    logic [63:0] w;
    logic        s;
    w  = {32'hFFFF_FFFF, 2'b01, op, prt, 5'h01, 2'b10, d};
    en = 1'b1;
    for (int k = 63; k >= 0; k--) begin
      if (op[1] && k < 18) en = 1'b0;
      cyc(w[k], s);
      if (k < 16) rd[k] = s;
    end
    @(negedge clock);
    mdc = 1'b0;
    en  = 1'b0;
  endtask
endmodule // mdio_station

// ### tb/xgmii64_client_and_mdio_mmd_tb.sv
// Self-checking bench for the client path and management slave
`timescale 1ns/100ps
`include "xgmii_mdio_map.vh"
module xgmii64_client_and_mdio_mmd_tb;
  localparam logic [4:0] PRT = 5'h11;
  localparam logic [4:0] OTH = 5'h02;
  // Management frames {op, port, data}
  localparam logic [22:0] T [15] = '{
    {2'h0, PRT, 16'h0003}, {2'h1, PRT, 16'hA5C3}, {2'h0, PRT, 16'h0004},
    {2'h1, PRT, 16'h5A3C}, {2'h0, PRT, 16'h0003}, {2'h2, PRT, 16'h0000},
    {2'h3, PRT, 16'h0000}, {2'h2, PRT, 16'h0000}, {2'h3, OTH, 16'h0000},
    {2'h1, OTH, 16'hFFFF}, {2'h3, PRT, 16'h0000}, {2'h0, PRT, 16'h000F},
    {2'h3, PRT, 16'h0000}, {2'h0, PRT, 16'h0020}, {2'h3, PRT, 16'h0000}};
  // Stimulus and observed signals
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        line_valid = 1'b0;
  logic        xgmii_rx_ready = 1'b0;
  logic [63:0] line_rxd = 64'h0;
  logic [7:0]  line_rxc = 8'h00;
  logic [7:0]  line_err = 8'h00;
  logic [63:0] xgmii_txd = {8{`CHAR_IDLE}};
  logic [7:0]  xgmii_txc = 8'hFF;
  logic [4:0]  prtad = PRT;
  logic [1:0]  type_sel = 2'h0;
  logic        line_ready, xgmii_rx_valid, tx_bad_start, mdc, mdio_out, mdio_oe, sdrv, sen;
  logic [63:0] xgmii_rxd, line_txd;
  logic [7:0]  xgmii_rxc, line_txc;
  logic [1:0]  map_select, exp_map;
  logic [72:0] ptx = {1'b0, 8'hFF, {8{`CHAR_IDLE}}};
  logic [71:0] q[$];
  logic [15:0] m_reg [16] = '{default: 16'h0};
  int          m_addr, n_errors, checked, i;
  // Management line: device, then station, else pull-up
  wire         mdio_in = mdio_oe ? mdio_out : (sen ? sdrv : 1'b1);

  always #20 clock = ~clock;

  xgmii_mdio_core dut (.*);
  mdio_station sta (.clock(clock), .line(mdio_in), .mdc(mdc), .drv(sdrv), .en(sen));

  // Compare and count
  task automatic check(input logic [72:0] seen, input logic [72:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Expected receive word: error lanes and stray starts become Error
  function automatic logic [71:0] fix(input logic [63:0] d, input logic [7:0] c,
                                      input logic [7:0] e);
    for (int n = 0; n < 8; n++)
      if (e[n] || (c[n] && d[8*n+:8] == `CHAR_START && n % 4 != 0)) begin
        d[8*n+:8] = `CHAR_ERROR;
        c[n] = 1'b1;
      end
    return {c, d};
  endfunction
  // One management frame against the register model
  task automatic mop(input logic [22:0] t);
    logic [15:0] rd, ex;
    sta.frame(t[22:21], t[20:16], t[15:0], rd);
    ex = 16'hFFFF;
    if (t[20:16] == PRT) begin
      ex = (m_addr == 15) ? {14'h0, exp_map} : (m_addr < 15 ? m_reg[m_addr] : 16'h0);
      if (t[22:21] == `OP_ADDRESS) m_addr = t[15:0];
      if (t[22:21] == `OP_WRITE && m_addr < 15) m_reg[m_addr] = t[15:0];
      if (t[22:21] == `OP_READ_INC) m_addr++;
    end
    if (t[22]) check(rd, ex);
    repeat (4) @(negedge clock);
    check(mdio_oe, 1'b0);
  endtask
  // Closing report
  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    results;
  end
  // Main sequence
  initial begin
    void'($urandom(67126));
    for (i = 0; i < 4; i++) begin
      type_sel = 2'(i);
      sys_rst  = 1'b1;
      repeat (10) @(negedge clock);
      sys_rst  = 1'b0;
      exp_map  = {type_sel[1], &type_sel};
      type_sel = ~type_sel;
      repeat (2) @(negedge clock);
      check(map_select, exp_map);
    end
    for (i = 0; i < 240; i++) begin
      @(negedge clock);
      line_valid     = 1'($urandom);
      xgmii_rx_ready = ($urandom % 4) < (i < 120 ? 1 : 3);
      {line_rxc, line_rxd} = {8'($urandom), $urandom, $urandom};
      line_rxd[8*(i%8)+:8] = `CHAR_START;
      line_err = 8'($urandom & $urandom & $urandom);
      {xgmii_txc, xgmii_txd} = {8'($urandom), $urandom, $urandom};
      xgmii_txd[8*((i+3)%8)+:8] = `CHAR_START;
      #1;
      check({tx_bad_start, line_txc, line_txd}, ptx);
      ptx = {fix(xgmii_txd, xgmii_txc, 8'h00) !== {xgmii_txc, xgmii_txd}, xgmii_txc, xgmii_txd};
      check({xgmii_rx_valid, line_ready}, {q.size() > 0, q.size() < 2});
      if (xgmii_rx_valid === 1'b1 && xgmii_rx_ready && q.size() > 0)
        check({xgmii_rxc, xgmii_rxd}, q.pop_front());
      if (line_valid && line_ready === 1'b1) q.push_back(fix(line_rxd, line_rxc, line_err));
    end
    line_valid = 1'b0;
    foreach (T[k]) mop(T[k]);
    results;
  end
endmodule // xgmii64_client_and_mdio_mmd_tb

// ### tb/xgmii_mdio_core_properties.sv
// Concurrent checks on the core's client and management ports
`timescale 1ns/100ps
`include "xgmii_mdio_map.vh"
module xgmii_mdio_props (
  // Clock and reset
  input logic        clock,
  input logic        sys_rst,
  // Receive side
  input logic        line_valid,
  input logic        line_ready,
  input logic [7:0]  line_err,
  input logic [63:0] xgmii_rxd,
  input logic [7:0]  xgmii_rxc,
  input logic        xgmii_rx_valid,
  input logic        xgmii_rx_ready,
  // Transmit side
  input logic [63:0] xgmii_txd,
  input logic [7:0]  xgmii_txc,
  input logic [63:0] line_txd,
  input logic [7:0]  line_txc,
  input logic        tx_bad_start,
  // Management
  input logic        mdio_out,
  input logic        mdio_oe,
  input logic [1:0]  type_sel,
  input logic [1:0]  map_select
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Start character outside lanes 0 and 4
  function automatic logic odd_start(input logic [63:0] d, input logic [7:0] c);
    odd_start = 1'b0;
    for (int n = 0; n < 8; n++)
      if (n % 4 != 0 && c[n] && d[8*n+:8] == `CHAR_START) odd_start = 1'b1;
  endfunction
  // Word into an empty buffer, then a second word with no pop
  sequence s_take;
    !xgmii_rx_valid && line_valid && line_ready;
  endsequence
  sequence s_fill;
    s_take ##1 line_valid && line_ready && !xgmii_rx_ready;
  endsequence
  property p_tx_copy;
    !$past(sys_rst) |-> line_txd == $past(xgmii_txd) && line_txc == $past(xgmii_txc);
  endproperty
  a_tx_copy: assert property (p_tx_copy) else $error("transmit word not copied");
  property p_bad_start;
    !$past(sys_rst) |-> tx_bad_start == odd_start($past(xgmii_txd), $past(xgmii_txc));
  endproperty
  a_bad_start: assert property (p_bad_start) else $error("start flag wrong");
  property p_rx_answer;
    s_take |=> xgmii_rx_valid;
  endproperty
  a_rx_answer: assert property (p_rx_answer) else $error("receive word not offered");
  property p_refuse;
    s_fill |=> !line_ready;
  endproperty
  a_refuse: assert property (p_refuse) else $error("full buffer still ready");
  property p_rx_hold;
    xgmii_rx_valid && !xgmii_rx_ready |=> xgmii_rx_valid && $stable(xgmii_rxd);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("stalled word changed");
  property p_err_mark;
    s_take ##0 line_err[4] |=> xgmii_rxd[39:32] == `CHAR_ERROR && xgmii_rxc[4];
  endproperty
  a_err_mark: assert property (p_err_mark) else $error("error lane not marked");
  property p_map_load;
    disable iff (1'b0) sys_rst |=> map_select == {$past(type_sel[1]), &$past(type_sel)};
  endproperty
  a_map_load: assert property (p_map_load) else $error("map not loaded");
  property p_map_hold;
    !$past(sys_rst) |-> $stable(map_select);
  endproperty
  a_map_hold: assert property (p_map_hold) else $error("map changed");
  property p_mdio_rest;
    $past(sys_rst) |-> !mdio_oe && mdio_out;
  endproperty
  a_mdio_rest: assert property (p_mdio_rest) else $error("line driven after reset");
endmodule // xgmii_mdio_props

bind xgmii_mdio_core xgmii_mdio_props props (.*);
